// ==== rtl/trp_defs.vh ====
// Constants shared by the temperature result path.
// Assumes inclusion by bare name from the design files; definitions only.
//
// Notes on behaviour
// - Remote reading steps bias base/N1, then base/N2, combining both voltage differences.
// - At slow conversion rates each result is the mean of 16 measurement cycles.
// - At 16, 32 and 64 conversions per second averaging is bypassed.
// - Local result, whole degrees, is read at address 0x00.
// - Remote whole byte sits at 0x01, fraction byte at 0x10.
// - Fraction byte: bit 7 is one half, bit 6 one quarter, rest zero.
// - Reading the fraction byte freezes remote result until whole byte is read.
// - After reset both channels use the 0 to 127 degree range.
// - Configuration bit 2 set selects -64 to 191 degrees; clear selects default.
// - A range change applies from the next measurement result onward.
// - A shorted remote diode leaves the last good remote result in place.
// - Default range stores plain unsigned binary degrees.
// - Extended range stores temperature plus 64 degrees.
// - Each new result is compared with its high and low limits.
// - Conversions alternate between local sensor and remote diode.
// - Conversion rate setting resets to code 0x08, sixteen per second.
// - Default range clamps below zero to 0 and above 127 to 127.
// - Range changes never touch limit values; only later results change format.
`ifndef TRP_DEFS_VH
`define TRP_DEFS_VH

`define TRP_ADDR_LOCAL 8'h00
`define TRP_ADDR_REM_WHOLE 8'h01
`define TRP_ADDR_CFG_RD 8'h03
`define TRP_ADDR_RATE_RD 8'h04
`define TRP_ADDR_CFG_WR 8'h09
`define TRP_ADDR_RATE_WR 8'h0a
`define TRP_ADDR_REM_FRAC 8'h10

`define TRP_CFG_RESET 8'h00
`define TRP_CFG_RANGE_BIT 2
`define TRP_CFG_STANDBY_BIT 6
`define TRP_CFG_USED_MASK 8'he4
`define TRP_RATE_RESET 4'h8
`define TRP_RATE_NOAVG_MIN 4'h8
`define TRP_RATE_MAX 4'ha

`define TRP_BIAS_BASE 2'h0
`define TRP_BIAS_N1 2'h1
`define TRP_BIAS_N2 2'h2
`define TRP_CHAN_LOCAL 1'b0
`define TRP_CHAN_REMOTE 1'b1

// Temperatures in quarter degrees
`define TRP_EXT_OFFSET_Q 13'h0100
`define TRP_BIN_MAX_Q 13'h01ff
`define TRP_EXT_MAX_Q 13'h03ff
`define TRP_AVG_LOG 4

// Slowest conversion period (16000 ms) and clock rate in MHz
`define TRP_SLOWEST_PERIOD_MS 32'h0000_3e80
`define TRP_CLK_MHZ 32'h0000_0064
`define TRP_CONV_BASE_CYCLES (`TRP_SLOWEST_PERIOD_MS * 32'h0000_03e8 * `TRP_CLK_MHZ)

`endif

// ==== rtl/trp_avg.v ====
// Sliding sixteen-sample mean of quarter-degree readings, with bypass.
// Assumes one clock and a synchronous active-low reset copy from the top.
`timescale 1ns/1ps
`include "trp_defs.vh"

module trp_avg #(
    parameter W = 12,
    parameter LOG = `TRP_AVG_LOG
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    input wire signed [W-1:0] in_data,
    input wire bypass,
    output reg out_valid,
    output reg signed [W-1:0] out_data
);
    localparam DEPTH = 1 << LOG;

    reg signed [W-1:0] window [0:DEPTH-1];
    reg [LOG-1:0] ptr;
    reg signed [W+LOG-1:0] sum;
    wire signed [W+LOG-1:0] next_sum;
    wire signed [W+LOG-1:0] in_ext;
    wire signed [W+LOG-1:0] old_ext;
    integer i;

    // Sign-extend both readings to the sum width before adding
    assign in_ext = {{LOG{in_data[W-1]}}, in_data};
    assign old_ext = {{LOG{window[ptr][W-1]}}, window[ptr]};

    // Running sum: add newest, drop the oldest it replaces
    assign next_sum = sum + in_ext - old_ext;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= {LOG{1'b0}};
            sum <= {(W+LOG){1'b0}};
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                window[i] <= {W{1'b0}};
            end
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                window[ptr] <= in_data;
                ptr <= ptr + 1'b1;
                sum <= next_sum;
                if (bypass) begin
                    out_data <= in_data;
                end else begin
                    out_data <= next_sum[W+LOG-1:LOG];
                end
            end
        end
    end
endmodule

// ==== rtl/trp_result_path.v ====
// Temperature result path: conversion timing, bias sequencing, averaging,
// range formatting, result registers with remote read lock, limit compare.
// Assumes a digital front end on the same clock that answers each start
// with one adc_valid pulse, and a serial slave that issues rd/wr strobes.
`timescale 1ns/1ps
`include "trp_defs.vh"

module trp_result_path #(
    parameter [31:0] CONV_BASE_CYCLES = `TRP_CONV_BASE_CYCLES,
    parameter W = 12,
    parameter signed [7:0] GAIN1 = 8'sh02,
    parameter signed [7:0] GAIN2 = 8'sh01,
    parameter SHIFT = 0
) (
    input wire clk,
    input wire rstn,
    input wire rd_en,
    input wire [7:0] rd_addr,
    output reg [7:0] rd_data,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [7:0] local_high_limit,
    input wire [7:0] local_low_limit,
    input wire [7:0] remote_high_limit,
    input wire [7:0] remote_low_limit,
    output reg adc_start,
    output reg adc_chan,
    output reg [1:0] bias_sel,
    input wire adc_valid,
    input wire signed [W-1:0] adc_sample,
    input wire adc_short,
    output reg local_high_flag,
    output reg local_low_flag,
    output reg remote_high_flag,
    output reg remote_low_flag
);
    localparam S_IDLE = 3'h0;
    localparam S_LOCAL = 3'h1;
    localparam S_RB1 = 3'h2;
    localparam S_RN1 = 3'h3;
    localparam S_RB2 = 3'h4;
    localparam S_RN2 = 3'h5;
    localparam signed [W:0] EXT_OFF = `TRP_EXT_OFFSET_Q;
    localparam signed [W:0] BIN_MAXQ = `TRP_BIN_MAX_Q;
    localparam signed [W:0] EXT_MAXQ = `TRP_EXT_MAX_Q;

    // Clamp and encode a quarter-degree reading as {whole, two fraction bits}
    function [9:0] fmt;
        input signed [W-1:0] q;
        input ext;
        reg signed [W:0] t;
        reg signed [W:0] maxq;
        begin
            t = {q[W-1], q};
            maxq = BIN_MAXQ;
            if (ext) begin
                t = t + EXT_OFF;
                maxq = EXT_MAXQ;
            end
            if (t[W]) begin
                fmt = 10'h000;
            end else if (t > maxq) begin
                fmt = {maxq[9:2], 2'b00};
            end else begin
                fmt = t[9:0];
            end
        end
    endfunction

    reg rst_meta;
    reg rst_sync;
    reg [7:0] cfg;
    reg [3:0] rate;
    reg [31:0] tick_cnt;
    reg tick;
    reg [2:0] state;
    reg signed [W-1:0] v_base1;
    reg signed [W-1:0] v_base2;
    reg signed [W:0] dv1;
    reg short_seen;
    reg loc_push;
    reg rem_push;
    reg signed [W-1:0] loc_q;
    reg signed [W-1:0] rem_q;
    reg [7:0] local_temperature_result;
    reg [7:0] remote_temperature_whole_byte;
    reg [7:0] remote_temperature_fraction_byte;
    reg remote_lock;

    wire range_ext = cfg[`TRP_CFG_RANGE_BIT];
    wire standby = cfg[`TRP_CFG_STANDBY_BIT];
    wire bypass = (rate >= `TRP_RATE_NOAVG_MIN);
    wire [3:0] rate_eff = (rate > `TRP_RATE_MAX) ? `TRP_RATE_MAX : rate;
    wire [31:0] period = CONV_BASE_CYCLES >> rate_eff;
    wire signed [W:0] dv2 = {adc_sample[W-1], adc_sample} - {v_base2[W-1], v_base2};
    wire signed [W+9:0] gain1_x = {{(W+2){GAIN1[7]}}, GAIN1};
    wire signed [W+9:0] gain2_x = {{(W+2){GAIN2[7]}}, GAIN2};
    wire signed [W+9:0] dv1_x = {{9{dv1[W]}}, dv1};
    wire signed [W+9:0] dv2_x = {{9{dv2[W]}}, dv2};
    wire signed [W+9:0] combo = gain1_x * dv1_x - gain2_x * dv2_x;
    wire signed [W+9:0] combo_sh = combo >>> SHIFT;
    wire loc_avg_valid;
    wire signed [W-1:0] loc_avg;
    wire rem_avg_valid;
    wire signed [W-1:0] rem_avg;
    wire [9:0] loc_fmt = fmt(loc_avg, range_ext);
    wire [9:0] rem_fmt = fmt(rem_avg, range_ext);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Configuration and rate registers
    always @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            cfg <= `TRP_CFG_RESET;
            rate <= `TRP_RATE_RESET;
        end else if (wr_en) begin
            if (wr_addr == `TRP_ADDR_CFG_WR) begin
                cfg <= wr_data & `TRP_CFG_USED_MASK;
            end
            if (wr_addr == `TRP_ADDR_RATE_WR) begin
                rate <= wr_data[3:0];
            end
        end
    end

    // Conversion period timer; cleared to zero while in standby
    always @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (standby) begin
                tick_cnt <= 32'h0000_0000;
            end else if (tick_cnt == 32'h0000_0000) begin
                tick <= 1'b1;
                tick_cnt <= (period == 32'h0000_0000) ? 32'h0000_0000 : period - 1'b1;
            end else begin
                tick_cnt <= tick_cnt - 1'b1;
            end
        end
    end

    // Measurement sequencer: local first, then the four remote bias steps
    always @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= S_IDLE;
            adc_start <= 1'b0;
            adc_chan <= `TRP_CHAN_LOCAL;
            bias_sel <= `TRP_BIAS_BASE;
            v_base1 <= {W{1'b0}};
            v_base2 <= {W{1'b0}};
            dv1 <= {(W+1){1'b0}};
            short_seen <= 1'b0;
            loc_push <= 1'b0;
            rem_push <= 1'b0;
            loc_q <= {W{1'b0}};
            rem_q <= {W{1'b0}};
        end else begin
            adc_start <= 1'b0;
            loc_push <= 1'b0;
            rem_push <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (tick) begin
                        state <= S_LOCAL;
                        adc_start <= 1'b1;
                        adc_chan <= `TRP_CHAN_LOCAL;
                        bias_sel <= `TRP_BIAS_BASE;
                    end
                end
                S_LOCAL: begin
                    if (adc_valid) begin
                        loc_push <= 1'b1;
                        loc_q <= adc_sample;
                        state <= S_RB1;
                        adc_start <= 1'b1;
                        adc_chan <= `TRP_CHAN_REMOTE;
                        bias_sel <= `TRP_BIAS_BASE;
                        short_seen <= 1'b0;
                    end
                end
                S_RB1: begin
                    if (adc_valid) begin
                        v_base1 <= adc_sample;
                        short_seen <= short_seen | adc_short;
                        state <= S_RN1;
                        adc_start <= 1'b1;
                        bias_sel <= `TRP_BIAS_N1;
                    end
                end
                S_RN1: begin
                    if (adc_valid) begin
                        dv1 <= {adc_sample[W-1], adc_sample} - {v_base1[W-1], v_base1};
                        short_seen <= short_seen | adc_short;
                        state <= S_RB2;
                        adc_start <= 1'b1;
                        bias_sel <= `TRP_BIAS_BASE;
                    end
                end
                S_RB2: begin
                    if (adc_valid) begin
                        v_base2 <= adc_sample;
                        short_seen <= short_seen | adc_short;
                        state <= S_RN2;
                        adc_start <= 1'b1;
                        bias_sel <= `TRP_BIAS_N2;
                    end
                end
                S_RN2: begin
                    if (adc_valid) begin
                        // Faulty diode readings never enter the average
                        rem_push <= ~(short_seen | adc_short);
                        rem_q <= combo_sh[W-1:0];
                        state <= S_IDLE;
                        bias_sel <= `TRP_BIAS_BASE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    trp_avg #(
        .W(W),
        .LOG(`TRP_AVG_LOG)
    ) u_avg_local (
        .clk(clk),
        .rst_n(rst_sync),
        .in_valid(loc_push),
        .in_data(loc_q),
        .bypass(bypass),
        .out_valid(loc_avg_valid),
        .out_data(loc_avg)
    );

    trp_avg #(
        .W(W),
        .LOG(`TRP_AVG_LOG)
    ) u_avg_remote (
        .clk(clk),
        .rst_n(rst_sync),
        .in_valid(rem_push),
        .in_data(rem_q),
        .bypass(bypass),
        .out_valid(rem_avg_valid),
        .out_data(rem_avg)
    );

    // Result registers, remote lock and limit compare
    always @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            local_temperature_result <= 8'h00;
            remote_temperature_whole_byte <= 8'h00;
            remote_temperature_fraction_byte <= 8'h00;
            remote_lock <= 1'b0;
            local_high_flag <= 1'b0;
            local_low_flag <= 1'b0;
            remote_high_flag <= 1'b0;
            remote_low_flag <= 1'b0;
        end else begin
            if (loc_avg_valid) begin
                // Format follows the range bit at the moment the result lands
                local_temperature_result <= loc_fmt[9:2];
                local_high_flag <= (loc_fmt[9:2] > local_high_limit);
                local_low_flag <= (loc_fmt[9:2] < local_low_limit);
            end
            if (rem_avg_valid) begin
                if (!remote_lock) begin
                    remote_temperature_whole_byte <= rem_fmt[9:2];
                    remote_temperature_fraction_byte <= {rem_fmt[1:0], 6'h00};
                end
                remote_high_flag <= (rem_fmt[9:2] > remote_high_limit);
                remote_low_flag <= (rem_fmt[9:2] < remote_low_limit);
            end
            if (rd_en && rd_addr == `TRP_ADDR_REM_FRAC) begin
                remote_lock <= 1'b1;
            end else if (rd_en && rd_addr == `TRP_ADDR_REM_WHOLE) begin
                remote_lock <= 1'b0;
            end
        end
    end

    // Read port, one cycle after the strobe
    always @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (rd_addr)
                `TRP_ADDR_LOCAL: rd_data <= local_temperature_result;
                `TRP_ADDR_REM_WHOLE: rd_data <= remote_temperature_whole_byte;
                `TRP_ADDR_REM_FRAC: rd_data <= remote_temperature_fraction_byte;
                `TRP_ADDR_CFG_RD: rd_data <= cfg;
                `TRP_ADDR_RATE_RD: rd_data <= {4'h0, rate};
                default: rd_data <= 8'h00;
            endcase
        end
    end
endmodule

// ==== test/trp_result_path_props.sv ====
// Checker for the result path ports: step order of the front end link and reads.
// Assumes a bind onto trp_result_path; one clock, rstn active low.
`timescale 1ns/1ps
module trp_result_path_props (
    input wire clk,
    input wire rstn,
    input wire rd_en,
    input wire [7:0] rd_addr,
    input wire [7:0] rd_data,
    input wire adc_start,
    input wire adc_chan,
    input wire [1:0] bias_sel,
    input wire adc_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    reg prev_chan;
    reg [1:0] prev_bias;
    reg [1:0] prev2_bias;
    wire unmapped = !(rd_addr == 8'h00 || rd_addr == 8'h01 || rd_addr == 8'h03 ||
        rd_addr == 8'h04 || rd_addr == 8'h10);
    // Channel of the step before the current one; bias of the two steps before it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_chan <= 1'b1;
            prev_bias <= 2'h2;
            prev2_bias <= 2'h0;
        end else if (adc_start) begin
            prev_chan <= adc_chan;
            prev_bias <= bias_sel;
            prev2_bias <= prev_bias;
        end
    end
    start_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("step start longer than one cycle");
    first_mult_a: assert property (adc_start && bias_sel == 2'h1 |-> adc_chan && prev_chan &&
        prev_bias == 2'h0) else $error("first multiple not after base");
    second_mult_a: assert property (adc_start && bias_sel == 2'h2 |-> adc_chan &&
        prev_bias == 2'h0 && prev2_bias == 2'h1) else $error("second multiple out of order");
    chan_alternate_a: assert property (adc_start && !adc_chan |-> bias_sel == 2'h0 && prev_chan &&
        prev_bias == 2'h2) else $error("local step not after full remote step");
    step_hold_a: assert property (!adc_start && !$past(adc_valid) |->
        $stable({adc_chan, bias_sel})) else $error("step select moved mid step");
    next_step_a: assert property (adc_valid && !(adc_chan && bias_sel == 2'h2) |=> adc_start)
        else $error("next step not started");
    unmapped_zero_a: assert property (rd_en && unmapped |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    frac_low_a: assert property (rd_en && rd_addr == 8'h10 |=> rd_data[5:0] == 6'h00)
        else $error("fraction low bits not zero");
    read_hold_a: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved without read");
endmodule
bind trp_result_path trp_result_path_props u_props (.clk(clk), .rstn(rstn), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .adc_start(adc_start), .adc_chan(adc_chan),
    .bias_sel(bias_sel), .adc_valid(adc_valid));

// ==== test/trp_fe_model.sv ====
// Front end model: answers each step start with one valid pulse lat+1 cycles after the edge that samples the start.
// Base steps read 0, multiple steps read remote_q, so combined remote equals remote_q.
`timescale 1ns/1ps
module trp_fe_model (
    input wire clk,
    input wire adc_start,
    input wire adc_chan,
    input wire [1:0] bias_sel,
    input wire [11:0] local_q,
    input wire [11:0] remote_q,
    input wire short_on,
    input wire [3:0] lat,
    output reg adc_valid,
    output reg [11:0] adc_sample,
    output reg adc_short
);
    reg busy = 1'b0;
    reg [3:0] cnt = 4'h0;
    initial begin
        adc_valid = 1'b0;
        adc_sample = 12'h000;
        adc_short = 1'b0;
    end
    always @(posedge clk) begin
        adc_valid <= 1'b0;
        adc_short <= 1'b0;
        // Sample is only meaningful with valid; scramble it otherwise
        if (adc_valid)
            adc_sample <= ~adc_sample;
        if (adc_start) begin
            busy <= 1'b1;
            cnt <= lat;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            adc_valid <= 1'b1;
            adc_short <= adc_chan & short_on;
            adc_sample <= !adc_chan ? local_q : (bias_sel == 2'h0 ? 12'h000 : remote_q);
        end
    end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for trp_result_path with a front end model.
// Assumes a short conversion base so a rate code 0x08 period is 64 cycles.
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg rd_en = 1'b0;
    reg wr_en = 1'b0;
    reg [7:0] rd_addr = 8'h00;
    reg [7:0] wr_addr = 8'h00;
    reg [7:0] wr_data = 8'h00;
    reg [7:0] local_high_limit = 8'hff;
    reg [7:0] local_low_limit = 8'h00;
    reg [7:0] remote_high_limit = 8'hff;
    reg [7:0] remote_low_limit = 8'h00;
    reg [11:0] local_q = 12'h000;
    reg [11:0] remote_q = 12'h000;
    reg short_on = 1'b0;
    reg [3:0] lat = 4'h0;
    wire [7:0] rd_data;
    wire [1:0] bias_sel;
    wire [11:0] adc_sample;
    wire adc_start, adc_chan, adc_valid, adc_short;
    wire local_high_flag, local_low_flag, remote_high_flag, remote_low_flag;
    integer miscompares = 0;
    integer num_checks = 0;
    integer r;
    always #5 clk = ~clk;
    trp_result_path #(.CONV_BASE_CYCLES(32'h0000_4000)) DUT (.clk(clk), .rstn(rstn),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .local_high_limit(local_high_limit), .local_low_limit(local_low_limit),
        .remote_high_limit(remote_high_limit), .remote_low_limit(remote_low_limit),
        .adc_start(adc_start), .adc_chan(adc_chan), .bias_sel(bias_sel), .adc_valid(adc_valid),
        .adc_sample(adc_sample), .adc_short(adc_short), .local_high_flag(local_high_flag),
        .local_low_flag(local_low_flag), .remote_high_flag(remote_high_flag),
        .remote_low_flag(remote_low_flag));
    trp_fe_model u_fe (.clk(clk), .adc_start(adc_start), .adc_chan(adc_chan),
        .bias_sel(bias_sel), .local_q(local_q), .remote_q(remote_q), .short_on(short_on),
        .lat(lat), .adc_valid(adc_valid), .adc_sample(adc_sample), .adc_short(adc_short));
    task finish_test;
        begin
            if (miscompares == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Read one register and compare; entered and left at a falling edge
    task rc(input [7:0] a, input [7:0] exp);
        begin
            rd_addr = a;
            rd_en = 1'b1;
            @(negedge clk);
            rd_en = 1'b0;
            @(negedge clk);
            check(rd_data, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            wr_addr = a;
            wr_data = d;
            wr_en = 1'b1;
            @(negedge clk);
            wr_en = 1'b0;
            @(negedge clk);
        end
    endtask
    // Wait for n local step starts, then let the whole conversion land
    task conv(input integer n);
        integer i, k;
        begin
            for (i = 0; i < n; i = i + 1) begin
                k = 0;
                while (!(adc_start === 1'b1 && adc_chan === 1'b0) && k < 20000) begin
                    @(negedge clk);
                    k = k + 1;
                end
                if (k == 20000) begin
                    miscompares = miscompares + 1;
                    $display("[FAIL] %0t conversion wait ran out", $time);
                    finish_test;
                end
                @(negedge clk);
            end
            repeat (40) @(negedge clk);
        end
    endtask
    task t_format;
        begin
            local_q = 12'h066;
            remote_q = 12'h0cb;
            conv(1);
            rc(8'h00, 8'h19);
            rc(8'h10, 8'hc0);
            rc(8'h01, 8'h32);
            local_q = 12'hffc;
            remote_q = 12'h320;
            conv(1);
            rc(8'h00, 8'h00);
            rc(8'h10, 8'h00);
            rc(8'h01, 8'h7f);
            wr(8'h09, 8'h1f);
            rc(8'h03, 8'h04);
            remote_q = 12'h259;
            conv(1);
            rc(8'h00, 8'h3f);
            rc(8'h10, 8'h40);
            rc(8'h01, 8'hd6);
            wr(8'h09, 8'h00);
        end
    endtask
    task t_lock_short;
        begin
            remote_q = 12'h195;
            conv(1);
            rc(8'h10, 8'h40);
            remote_q = 12'h07a;
            local_q = 12'h0a0;
            conv(2);
            rc(8'h00, 8'h28);
            rc(8'h01, 8'h65);
            conv(1);
            rc(8'h10, 8'h80);
            rc(8'h01, 8'h1e);
            short_on = 1'b1;
            remote_q = 12'h190;
            conv(2);
            rc(8'h10, 8'h80);
            rc(8'h01, 8'h1e);
            short_on = 1'b0;
            conv(1);
            rc(8'h01, 8'h64);
        end
    endtask
    task t_limits;
        begin
            lat = 4'h3;
            local_q = 12'h078;
            remote_q = 12'h0c8;
            local_high_limit = 8'h1d;
            local_low_limit = 8'h14;
            remote_high_limit = 8'h64;
            remote_low_limit = 8'h3c;
            conv(1);
            check({7'h00, local_high_flag}, 8'h01);
            check({7'h00, local_low_flag}, 8'h00);
            check({7'h00, remote_high_flag}, 8'h00);
            check({7'h00, remote_low_flag}, 8'h01);
            wr(8'h09, 8'h04);
            conv(1);
            check({7'h00, remote_high_flag}, 8'h01);
            check({7'h00, remote_low_flag}, 8'h00);
            wr(8'h09, 8'h00);
            lat = 4'h0;
        end
    endtask
    task t_avg;
        begin
            wr(8'h0a, 8'h07);
            local_q = 12'h0a0;
            remote_q = 12'h0a0;
            conv(16);
            rc(8'h00, 8'h28);
            local_q = 12'h0e6;
            remote_q = 12'h10e;
            conv(1);
            rc(8'h00, 8'h29);
            rc(8'h10, 8'h80);
            rc(8'h01, 8'h29);
            for (r = 8; r < 11; r = r + 1) begin
                wr(8'h0a, r[7:0]);
                local_q = {2'h0, r[7:0], 2'h1};
                conv(1);
                rc(8'h00, r[7:0]);
            end
        end
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        rc(8'h03, 8'h00);
        rc(8'h04, 8'h08);
        rc(8'h05, 8'h00);
        t_format;
        t_lock_short;
        t_limits;
        t_avg;
        finish_test;
    end
endmodule
